/* File: core/lcd_rotation_power_seq.sv */
// Panel power gating and rotation address registers behind AHB-Lite
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/100ps
module lcd_rotation_power_seq
(
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       hsel_in,
  input  wire logic [31:0]                haddr_in,
  input  wire logic [1:0]                 htrans_in,
  input  wire logic                       hwrite_in,
  input  wire logic [2:0]                 hsize_in,
  input  wire logic [31:0]                hwdata_in,
  input  wire logic                       hready_in,
  output logic      [31:0]                hrdata_out,
  output logic                            hreadyout_out,
  output logic                            hresp_out,
  input  wire logic                       frame_start_in,
  input  wire logic                       fetch_step_in,
  input  wire logic                       line_end_in,
  output lcd_rot_pkg::dword_addr_t        fetch_addr_out,
  output lcd_rot_pkg::rot_mode_t          rotation_mode_out,
  output logic [lcd_rot_pkg::DEPTH_W-1:0] color_depth_out,
  output logic                            panel_signals_on_out,
  output logic                            general_output_pin_out
);
  import lcd_rot_pkg::*;

  typedef struct packed {
    logic         wr_pend;
    reg_idx_t     wr_idx;
    logic [31:0]  rdata;
    logic [7:0]   disp_ctrl;
    logic [7:0]   effects;
    dword_addr_t  start;
    line_offset_t line_off;
    logic         bias_on;
  } regs_state_t;

  regs_state_t state_reg;
  regs_state_t state_next;

  fetch_if fetch ();

  lcd_fetch_walker walker
  (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .fetch  (fetch.walk)
  );

  // Narrow registers sit in the low byte; unmapped words read as zero
  function automatic logic [31:0] read_reg(reg_idx_t idx, regs_state_t r,
                                           rot_mode_t live_mode);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      IDX_DISP_CTRL:  b = r.disp_ctrl;
      IDX_EFFECTS:    b = r.effects;
      IDX_START_LO:   b = r.start[7:0];
      IDX_START_MID:  b = r.start[15:8];
      IDX_START_HI:   b = {7'h00, r.start[START_HI_BIT]};
      IDX_OFFSET_LO:  b = r.line_off[7:0];
      IDX_OFFSET_HI:  b = {6'h00, r.line_off[OFFS_W-1:8]};
      IDX_BIAS_CTRL:  b = {7'h00, r.bias_on};
      IDX_FETCH_STAT: b = {6'h00, live_mode};
      default:        b = 8'h00;
    endcase
    return {24'h000000, b};
  endfunction

  always_comb
  begin
    state_next = state_reg;
    // Data phase of a write accepted on the previous edge
    if (state_reg.wr_pend)
    begin
      case (state_reg.wr_idx)
        IDX_DISP_CTRL:
          state_next.disp_ctrl = hwdata_in[7:0] & DISP_CTRL_MASK;
        IDX_EFFECTS:
          state_next.effects = hwdata_in[7:0] & EFFECTS_MASK;
        IDX_START_LO:
          state_next.start[7:0] = hwdata_in[7:0];
        IDX_START_MID:
          state_next.start[15:8] = hwdata_in[7:0];
        IDX_START_HI:
          state_next.start[START_HI_BIT] = hwdata_in[0];
        IDX_OFFSET_LO:
          state_next.line_off[7:0] = hwdata_in[7:0];
        IDX_OFFSET_HI:
          state_next.line_off[OFFS_W-1:8] = hwdata_in[1:0];
        IDX_BIAS_CTRL:
          state_next.bias_on = hwdata_in[0];
        default:
          state_next.bias_on = state_reg.bias_on;
      endcase
    end
    state_next.wr_pend = 1'b0;
    // Zero wait states: read data is fetched at the address phase edge.
    // It is taken from the post-write copy so a read right behind a
    // write to the same word returns the new value.
    if (hsel_in && (htrans_in == HTRANS_NONSEQ) && hready_in)
    begin
      state_next.wr_pend = hwrite_in;
      state_next.wr_idx  = haddr_in[IDX_W+1:2];
      if (!hwrite_in)
        state_next.rdata = read_reg(haddr_in[IDX_W+1:2], state_next,
                                    fetch.cur_mode);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_reg           <= '0;
      state_reg.disp_ctrl <= DISP_CTRL_RESET;
      state_reg.effects   <= EFFECTS_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Walker takes these only on frame start, so a half-written
  // multi-byte value mid-frame never reaches the fetch address
  assign fetch.start       = state_reg.start;
  assign fetch.line_off    = state_reg.line_off;
  assign fetch.mode        = rot_mode_t'(state_reg.effects[ROT_LSB +: ROT_W]);
  assign fetch.frame_start = frame_start_in;
  assign fetch.step        = fetch_step_in;
  assign fetch.line_end    = line_end_in;

  assign hrdata_out    = state_reg.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = HRESP_OKAY;

  assign fetch_addr_out    = fetch.fetch_addr;
  assign rotation_mode_out = fetch.cur_mode;
  assign color_depth_out   = state_reg.disp_ctrl[DEPTH_LSB +: DEPTH_W];
  // Signals stay off while blanked; sequencing against the bias output
  // is left to software, the hardware imposes no delay between them
  assign panel_signals_on_out   = ~state_reg.disp_ctrl[BLANK_BIT];
  assign general_output_pin_out = state_reg.bias_on;
endmodule

/* File: core/lcd_rot_pkg.sv */
// Constants for the panel power and rotation address block
// How it works
// - Clearing the blank bit turns the panel interface signals on, setting it shuts them down.
// - The two-bit rotation field turns the image counter-clockwise by 0, 90, 180 or 270 degrees.
// - Rotation works the same at 1, 2, 4, 8 and 16 bits per pixel.
// - The main start address is a 17-bit dword address in three byte registers, zero is buffer start.
// - The line offset is a 10-bit dword stride between image lines in two byte registers.
package lcd_rot_pkg;
  localparam int ADDR_W = 17;
  localparam int OFFS_W = 10;
  localparam int IDX_W  = 9;

  typedef logic [ADDR_W-1:0] dword_addr_t;
  typedef logic [OFFS_W-1:0] line_offset_t;
  typedef logic [IDX_W-1:0]  reg_idx_t;

  typedef enum logic [1:0] {
    ROT_0   = 2'b00,
    ROT_90  = 2'b01,
    ROT_180 = 2'b10,
    ROT_270 = 2'b11
  } rot_mode_t;

  // Register indices; byte address is four times the index
  localparam reg_idx_t IDX_DISP_CTRL   = 9'h070;
  localparam reg_idx_t IDX_EFFECTS     = 9'h071;
  localparam reg_idx_t IDX_START_LO    = 9'h074;
  localparam reg_idx_t IDX_START_MID   = 9'h075;
  localparam reg_idx_t IDX_START_HI    = 9'h076;
  localparam reg_idx_t IDX_OFFSET_LO   = 9'h078;
  localparam reg_idx_t IDX_OFFSET_HI   = 9'h079;
  localparam reg_idx_t IDX_BIAS_CTRL   = 9'h07A;
  localparam reg_idx_t IDX_FETCH_STAT  = 9'h07B;

  localparam int BLANK_BIT  = 7;
  localparam int DEPTH_LSB  = 0;
  localparam int DEPTH_W    = 3;
  localparam int ROT_LSB    = 0;
  localparam int ROT_W      = 2;
  localparam int START_HI_BIT = 16;

  localparam logic [7:0] DISP_CTRL_MASK  = 8'h87;
  localparam logic [7:0] EFFECTS_MASK    = 8'hD3;
  localparam logic [7:0] DISP_CTRL_RESET = 8'h80;
  localparam logic [7:0] EFFECTS_RESET   = 8'h00;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic       HRESP_OKAY    = 1'b0;
endpackage

/* File: core/fetch_if.sv */
// Link between register file and the fetch address walker
`timescale 1ns/100ps
interface fetch_if;
  import lcd_rot_pkg::*;
  dword_addr_t  start;
  line_offset_t line_off;
  rot_mode_t    mode;
  logic         frame_start;
  logic         step;
  logic         line_end;
  dword_addr_t  fetch_addr;
  rot_mode_t    cur_mode;

  modport ctl  (output start, line_off, mode, frame_start, step, line_end,
                input  fetch_addr, cur_mode);
  modport walk (input  start, line_off, mode, frame_start, step, line_end,
                output fetch_addr, cur_mode);
endinterface

/* File: core/lcd_fetch_walker.sv */
// Display buffer fetch address walker with rotation
`timescale 1ns/100ps
module lcd_fetch_walker
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  fetch_if.walk     fetch
);
  import lcd_rot_pkg::*;

  typedef struct packed {
    rot_mode_t    mode;
    line_offset_t off;
    dword_addr_t  base;
    dword_addr_t  addr;
  } walk_state_t;

  walk_state_t state_reg;
  walk_state_t state_next;

  // Step in dwords; along the output line or from one line to the next.
  // Rotation only changes the walk order, so every colour depth is served
  // by the same arithmetic.
  function automatic dword_addr_t step_of(rot_mode_t m, line_offset_t o,
                                          logic along);
    dword_addr_t one;
    dword_addr_t stride;
    dword_addr_t res;
    one    = dword_addr_t'(1);
    stride = dword_addr_t'(o);
    case (m)
      ROT_0:   res = along ? one : stride;
      ROT_90:  res = along ? stride : dword_addr_t'(-one);
      ROT_180: res = along ? dword_addr_t'(-one) : dword_addr_t'(-stride);
      ROT_270: res = along ? dword_addr_t'(-stride) : one;
      default: res = one;
    endcase
    return res;
  endfunction

  always_comb
  begin
    state_next = state_reg;
    if (fetch.frame_start)
    begin
      state_next.mode = fetch.mode;
      state_next.off  = fetch.line_off;
      state_next.base = fetch.start;
      state_next.addr = fetch.start;
    end
    else if (fetch.line_end)
    begin
      state_next.base = dword_addr_t'(state_reg.base
                        + step_of(state_reg.mode, state_reg.off, 1'b0));
      state_next.addr = state_next.base;
    end
    else if (fetch.step)
    begin
      state_next.addr = dword_addr_t'(state_reg.addr
                        + step_of(state_reg.mode, state_reg.off, 1'b1));
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign fetch.fetch_addr = state_reg.addr;
  assign fetch.cur_mode   = state_reg.mode;
endmodule

/* File: bench/lcd_rot_chk.sv */
// Assertion checker for the panel power and rotation block
`timescale 1ns/100ps
module lcd_rot_chk
  import lcd_rot_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic        frame_start_in,
  input wire logic        fetch_step_in,
  input wire logic        line_end_in,
  input wire dword_addr_t fetch_addr_out,
  input wire rot_mode_t   rotation_mode_out,
  input wire logic        panel_signals_on_out,
  input wire logic        general_output_pin_out
);
  logic     wr_ph_reg;
  reg_idx_t wr_idx_reg;
  logic     step_only;
  logic     quiet;
  assign step_only = fetch_step_in && !frame_start_in && !line_end_in;
  assign quiet = !(frame_start_in || fetch_step_in || line_end_in);
  // Marks the data phase of a write, when hwdata is stored
  always_ff @(posedge clk_in)
  begin
    wr_ph_reg  <= !rst_in && hsel_in && hwrite_in && hready_in
                  && htrans_in == HTRANS_NONSEQ;
    wr_idx_reg <= haddr_in[10:2];
  end
  default clocking dcb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_blank_to_panel:
  assert property (wr_ph_reg && wr_idx_reg == IDX_DISP_CTRL |=>
    panel_signals_on_out == !$past(hwdata_in[BLANK_BIT]))
    else $error("panel signals do not follow blank bit");
  a_bias_to_pin:
  assert property (wr_ph_reg && wr_idx_reg == IDX_BIAS_CTRL |=>
    general_output_pin_out == $past(hwdata_in[0]))
    else $error("bias pin does not follow its bit");
  a_step_normal:
  assert property (step_only && rotation_mode_out == ROT_0 |=>
    fetch_addr_out == dword_addr_t'($past(fetch_addr_out) + 17'h1))
    else $error("normal step is not plus one");
  a_step_half_turn:
  assert property (step_only && rotation_mode_out == ROT_180 |=>
    fetch_addr_out == dword_addr_t'($past(fetch_addr_out) - 17'h1))
    else $error("half turn step is not minus one");
  a_mode_frame_only:
  assert property (!frame_start_in |=> $stable(rotation_mode_out))
    else $error("mode changed outside frame start");
  a_addr_holds:
  assert property (quiet |=> $stable(fetch_addr_out))
    else $error("fetch address moved without a pulse");
  a_reset_values:
  assert property (disable iff (1'b0) rst_in |=> !panel_signals_on_out
    && !general_output_pin_out && fetch_addr_out == 17'h0)
    else $error("outputs not at reset values");
  a_bus_okay:
  assert property (hreadyout_out && hresp_out == HRESP_OKAY)
    else $error("bus wait or error response");
endmodule

/* File: bench/panel_model.sv */
// Panel and bias supply model that flags unsafe power ordering
`timescale 1ns/100ps
module panel_model
#(
  parameter int WAIT_CYC = 8
)
(
  input  wire logic clk_in,
  input  wire logic signals_on_in,
  input  wire logic bias_on_in,
  output logic      fault_out
);
  int unsigned on_cnt = 0;
  int unsigned off_cnt = 1000;
  initial fault_out = 1'b0;
  // Bias on a dark or freshly lit panel, or signals cut while bias drains
  always @(posedge clk_in)
  begin
    on_cnt  <= signals_on_in ? on_cnt + 1 : 0;
    off_cnt <= bias_on_in ? 0 : off_cnt + 1;
    if (bias_on_in && (!signals_on_in || on_cnt < WAIT_CYC))
      fault_out <= 1'b1;
    if (!signals_on_in && off_cnt < WAIT_CYC)
      fault_out <= 1'b1;
  end
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the panel power and rotation block
`timescale 1ns/100ps
module testbench;
  import lcd_rot_pkg::*;
  logic        clk_in, rst_in, hsel_in, hwrite_in, fault;
  logic        frame_start_in, fetch_step_in, line_end_in;
  logic        hreadyout_out, hresp_out, panel_signals_on_out;
  logic        general_output_pin_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out;
  logic [1:0]  htrans_in;
  logic [2:0]  hsize_in, color_depth_out;
  wire         hready_in = hreadyout_out;
  dword_addr_t fetch_addr_out;
  rot_mode_t   rotation_mode_out;
  int          mismatches = 0;
  int          cmp_count = 0;
  logic [31:0] seed = 32'h13658;
  // Panel size keeps width a multiple of 32/bpp at every depth; height is one at every depth except 1 bpp
  localparam int PANEL_W = 320;
  localparam int PANEL_H = 240;
  lcd_rotation_power_seq u_dut (.*);
  panel_model u_panel (.clk_in(clk_in), .signals_on_in(panel_signals_on_out),
    .bias_on_in(general_output_pin_out), .fault_out(fault));
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Address move for a step (ln=0) or a line end (ln=1)
  // Start register value for a window at byte address ba; division drops
  // any fraction before the value is written
  function automatic dword_addr_t start_for(logic [1:0] m, int ba, int w,
                                            int h, int bpp);
    int v;
    case (m)
      2'h0:    v = ba / 4;
      2'h1:    v = (ba + h * bpp / 8) / 4 - 1;
      2'h2:    v = (ba + w * h * bpp / 8) / 4 - 1;
      default: v = (ba + (w - 1) * h * bpp / 8) / 4;
    endcase
    return dword_addr_t'(v);
  endfunction
  // Dwords per image line, rounded up
  function automatic line_offset_t off_for(int wimg, int bpp);
    return line_offset_t'((wimg * bpp + 31) / 32);
  endfunction
  function automatic dword_addr_t mv(logic [1:0] m, line_offset_t o,
                                     logic ln);
    dword_addr_t d;
    d = (m[0] ^ ln) ? dword_addr_t'(o) : 17'h1;
    return (ln ? m[0] ^ m[1] : m[1]) ? -d : d;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(logic w, reg_idx_t i, logic [7:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge clk_in);
    hsel_in   <= 1'b1;
    htrans_in <= HTRANS_NONSEQ;
    hwrite_in <= w;
    haddr_in  <= {21'h0, i, 2'b00};
    n = 0;
    do @(posedge clk_in); while (hready_in !== 1'b1 && ++n < 50);
    hsel_in   <= 1'b0;
    htrans_in <= 2'b00;
    hwdata_in <= {seed[31:8], d};
    do @(posedge clk_in); while (hready_in !== 1'b1 && ++n < 50);
    r = hrdata_out;
    if (n >= 50)
      mismatches++;
  endtask
  task automatic wr(input reg_idx_t i, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, i, d, x);
    #1;
  endtask
  task automatic rdchk(input reg_idx_t i, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, i, 8'h00, x);
    chk(x, e);
  endtask
  task automatic pulse(input logic [2:0] p);
    @(posedge clk_in);
    {frame_start_in, line_end_in, fetch_step_in} <= p;
    @(posedge clk_in);
    {frame_start_in, line_end_in, fetch_step_in} <= 3'h0;
    #1;
  endtask
  task automatic summarize;
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #400000;
    mismatches++;
    summarize();
  end
  initial
  begin
    dword_addr_t  st;
    line_offset_t of;
    logic [1:0]   m;
    {hsel_in, hwrite_in, htrans_in, haddr_in, hwdata_in} = '0;
    {frame_start_in, line_end_in, fetch_step_in} = 3'h0;
    hsize_in = 3'h2;
    rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rdchk(IDX_DISP_CTRL, {24'h0, DISP_CTRL_RESET});
    rdchk(9'h1FF, 32'h0);
    wr(IDX_DISP_CTRL, 8'h00);
    chk(panel_signals_on_out, 32'h1);
    repeat (10) @(posedge clk_in);
    wr(IDX_BIAS_CTRL, 8'h01);
    chk(general_output_pin_out, 32'h1);
    wr(IDX_BIAS_CTRL, 8'h00);
    repeat (10) @(posedge clk_in);
    wr(IDX_DISP_CTRL, 8'h80);
    chk(panel_signals_on_out, 32'h0);
    chk(fault, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      m = i[1:0];
      seed = lfsr(seed);
      st = (i == 0) ? 17'h1FFFF
           : start_for(m, int'(seed[15:0]), PANEL_W, PANEL_H, 1 << i);
      // A line longer than the image is a legal virtual display
      of = (i == 1) ? 10'h01E
           : off_for(m[0] ? PANEL_H : PANEL_W, 1 << i) | seed[26:17];
      wr(IDX_START_LO, st[7:0]);
      wr(IDX_START_MID, st[15:8]);
      wr(IDX_START_HI, {7'h0, st[16]});
      wr(IDX_OFFSET_LO, of[7:0]);
      wr(IDX_OFFSET_HI, {6'h0, of[9:8]});
      wr(IDX_EFFECTS, {6'h0, m});
      // Blank stays set; the bench never touches a colour lookup table
      wr(IDX_DISP_CTRL, {5'h10, i[2:0]});
      rdchk(IDX_START_HI, {31'h0, st[16]});
      rdchk(IDX_OFFSET_HI, {30'h0, of[9:8]});
      pulse(3'b110);
      chk(fetch_addr_out, st);
      chk(rotation_mode_out, m);
      chk(color_depth_out, i);
      rdchk(IDX_FETCH_STAT, m);
      wr(IDX_START_LO, ~st[7:0]);
      pulse(3'b001);
      chk(fetch_addr_out, dword_addr_t'(st + mv(m, of, 1'b0)));
      pulse(3'b011);
      chk(fetch_addr_out, dword_addr_t'(st + mv(m, of, 1'b1)));
      pulse(3'b100);
      chk(fetch_addr_out, {st[16:8], ~st[7:0]});
    end
    chk(fault, 32'h0);
    summarize();
  end
endmodule
bind lcd_rotation_power_seq lcd_rot_chk u_chk (.*);
